// [bench/keypad_model.sv]
// Operator keypad and dry contacts in front of the mode selector.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`default_nettype none
module keypad_model (
   // Clock
   input  wire logic       pclk,
   // Keys and contacts
   output logic            key_up,
   output logic            key_down,
   output logic            key_shift,
   output logic            key_direct,
   output logic      [1:0] contact_input
);
   timeunit 1ns;
   timeprecision 1ns;
   // All keys released and contacts open at power-up
   initial begin
      {key_up, key_down, key_shift, key_direct, contact_input} = 6'h00;
   end
   // Keys {up,down,shift,direct} held n cycles; two idle edges after release
   task automatic press(input logic [3:0] k, input int n);
      @(posedge pclk);
      {key_up, key_down, key_shift, key_direct} <= k;
      repeat (n) @(posedge pclk);
      {key_up, key_down, key_shift, key_direct} <= 4'h0;
      repeat (2) @(posedge pclk);
   endtask : press
   // Clean contact change; bounce is not modelled
   task automatic set_contact(input logic [1:0] c);
      @(posedge pclk);
      contact_input <= c;
   endtask : set_contact
endmodule : keypad_model
`default_nettype wire

// [bench/mode_select_monitor.sv]
// Port checker for the mode selector, attached to every instance by bind.
// Assumes one clock, an asynchronous active-low reset and the defines header map.
`include "mode_select_defines.svh"
`default_nettype none
module mode_select_monitor #(
   parameter int unsigned MS_CYCLES = 10,
   parameter int unsigned OUT_WIDTH = 16,
   parameter int unsigned OUT_MAX   = 1000
) (
   // Clock, reset, enable
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 ce,
   // APB
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [7:0]           paddr,
   input wire logic [31:0]          pwdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // Keys and outputs
   input wire logic                 key_up,
   input wire logic                 key_down,
   input wire logic [OUT_WIDTH-1:0] manipulated_output_value,
   input wire logic                 pid_preset,
   input wire logic [OUT_WIDTH-1:0] pid_preset_value,
   input wire logic                 manual_mode_lamp,
   input wire logic                 remote_mode_lamp,
   input wire logic                 open_side_output,
   input wire logic                 close_side_output,
   input wire logic [2:0]           screen
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Run bit as last written; the lamp flops lag it by one cycle
   logic run_seen;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) run_seen <= 1'b1;
      else if (ce && psel && penable && pready && pwrite && paddr == `CTRL_ADDR) run_seen <= pwdata[`CTRL_RUN];
   end
   // Setup phase, and a stop that has had a cycle to reach the lamps
   sequence setup_s;
      ce && psel && !penable;
   endsequence
   sequence stopped_s;
      !run_seen ##1 !run_seen;
   endsequence
   AST_APB_ANSWER: assert property (setup_s |=> pready && psel && penable)
      else $error("no answer in the access phase");
   AST_APB_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_UNMAPPED: assert property (pslverr |-> pready
      && !(paddr inside {`CTRL_ADDR, `SAMPLE_ADDR, `STATUS_ADDR, `OUTPUT_ADDR}))
      else $error("pslverr on a mapped address");
   AST_MAN_DARK: assert property (stopped_s |-> !manual_mode_lamp)
      else $error("manual lamp lit while stopped");
   AST_REM_DARK: assert property (stopped_s |-> !remote_mode_lamp)
      else $error("remote lamp lit while stopped");
   AST_OPEN_KEY: assert property (open_side_output |-> $past(key_up) || $past(key_up, 2))
      else $error("open output without up key");
   AST_CLOSE_KEY: assert property (close_side_output |-> $past(key_down) || $past(key_down, 2))
      else $error("close output without down key");
   AST_ONE_SIDE: assert property (!(open_side_output && close_side_output))
      else $error("open and close outputs together");
   AST_PRESET_VALUE: assert property (pid_preset |-> pid_preset_value == $past(manipulated_output_value))
      else $error("preset value is not the manual output");
   AST_PRESET_HOLD: assert property ($changed(pid_preset_value) |-> pid_preset)
      else $error("preset value moved without a preset");
   AST_PRESET_PULSE: assert property (pid_preset |=> !pid_preset)
      else $error("preset pulse too long");
   AST_MV_LIMIT: assert property (manual_mode_lamp |-> manipulated_output_value <= OUT_MAX)
      else $error("manual output above its limit");
   AST_SCREEN_ONEHOT: assert property ($onehot(screen))
      else $error("screen code not one-hot");
endmodule : mode_select_monitor
bind mode_select mode_select_monitor #(.MS_CYCLES(MS_CYCLES), .OUT_WIDTH(OUT_WIDTH), .OUT_MAX(OUT_MAX)) checker_i (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .key_up(key_up), .key_down(key_down),
   .manipulated_output_value(manipulated_output_value), .pid_preset(pid_preset), .pid_preset_value(pid_preset_value),
   .manual_mode_lamp(manual_mode_lamp), .remote_mode_lamp(remote_mode_lamp), .open_side_output(open_side_output),
   .close_side_output(close_side_output), .screen(screen));
`default_nettype wire

// [bench/mode_select_test.sv]
// Self-checking bench for the mode selector: APB registers and keypad scenarios.
// Assumes the keypad model drives keys and contacts; ms timing is scaled down.
`include "mode_select_defines.svh"
`default_nettype none
module mode_select_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned MSC = 10; // Ten clocks per ms keeps 2 s holds short
   // Bus and loop signals
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        key_up, key_down, key_shift, key_direct;
   logic [1:0]  contact_input;
   logic [15:0] auto_output, mv, preset_value, held;
   logic        pid_preset, man_lamp, rem_lamp, hidden, open_out, close_out;
   logic [2:0]  screen;
   int          errors, comparisons;
   mode_select #(.MS_CYCLES(MSC)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_up(key_up), .key_down(key_down), .key_shift(key_shift), .key_direct(key_direct),
      .contact_input(contact_input), .auto_output(auto_output), .manipulated_output_value(mv),
      .pid_preset(pid_preset), .pid_preset_value(preset_value), .manual_mode_lamp(man_lamp),
      .remote_mode_lamp(rem_lamp), .output_hidden(hidden), .open_side_output(open_out),
      .close_side_output(close_out), .screen(screen));
   keypad_model kp (.pclk(pclk), .key_up(key_up), .key_down(key_down), .key_shift(key_shift),
      .key_direct(key_direct), .contact_input(contact_input));
   // 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic check_bit(input string name, input logic exp, input logic seen);
      check(name, {31'h0, exp}, {31'h0, seen});
   endtask : check_bit
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) errors++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0, rd, err);
      check(name, exp, rd);
   endtask : rd_chk
   task automatic results;
      $display("Comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // Watchdog well beyond the roughly 48k cycles of the sequence
   initial begin
      repeat (90000) @(posedge pclk);
      errors++;
      results();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
      auto_output = 16'h012C;
      errors = 0;
      comparisons = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`CTRL_ADDR, 32'h0000000C, "ctrl");
      rd_chk(`SAMPLE_ADDR, 32'h00000064, "sample");
      wr(`SAMPLE_ADDR, 32'h0000000A);
      wr(`STATUS_ADDR, 32'h0000FFFF);
      rd_chk(`STATUS_ADDR, 32'h00000021, "status");
      apb(1'b0, 8'h10, 32'h0, rd, err);
      check_bit("slverr", 1'b1, err);
      // Direct key into manual, stepping, fast repeat, back to auto
      wr(`CTRL_ADDR, 32'h0000001C);
      kp.press(4'h1, 1);
      check_bit("man_lamp", 1'b1, man_lamp);
      check("mv_bumpless", 32'h0000012C, {16'h0, mv});
      auto_output <= 16'h0200;
      kp.press(4'h8, 1);
      check("mv_up", 32'h0000012D, {16'h0, mv});
      kp.press(4'h4, 1);
      check("mv_down", 32'h0000012C, {16'h0, mv});
      kp.press(4'h8, 600 * MSC);
      check_bit("mv_fast", 1'b1, mv > 16'h012E);
      held = mv;
      kp.press(4'h1, 1);
      check_bit("man_off", 1'b0, man_lamp);
      check("preset", {16'h0, held}, {16'h0, preset_value});
      // Stop while manual: lamp dark, mode kept
      kp.press(4'h1, 1);
      wr(`CTRL_ADDR, 32'h00000019);
      rd_chk(`STATUS_ADDR, 32'h00000022, "status_stop");
      check_bit("man_stop", 1'b0, man_lamp);
      wr(`CTRL_ADDR, 32'h0000002C);
      kp.press(4'h1, 1);
      check_bit("rem_on", 1'b1, rem_lamp);
      kp.press(4'h1, 1);
      check_bit("rem_off", 1'b0, rem_lamp);
      // Position mode without feedback: keys drive open and close outputs
      auto_output <= 16'h0300;
      wr(`CTRL_ADDR, 32'h00000105);
      for (int i = 0; i < 2; i++) begin
         fork
            kp.press(i == 0 ? 4'h8 : 4'h4, 5);
            begin
               repeat (4) @(posedge pclk);
               check_bit("side_on", 1'b1, i == 0 ? open_out : close_out);
               check_bit("hidden", 1'b1, hidden);
            end
         join
         check_bit("side_off", 1'b0, open_out | close_out);
      end
      check("mv_stored", 32'h00000200, {16'h0, mv});
      wr(`CTRL_ADDR, 32'h00000305);
      kp.press(4'h8, 1);
      check("mv_valve", 32'h00000201, {16'h0, mv});
      // Contact assigned: open forces manual, closing gives auto after 200 ms plus a sample
      wr(`CTRL_ADDR, 32'h0000004C);
      repeat (3) @(posedge pclk);
      check_bit("contact_open", 1'b1, man_lamp);
      kp.set_contact(2'b01);
      repeat (200 * MSC) @(posedge pclk);
      check_bit("contact_wait", 1'b1, man_lamp);
      repeat (30 * MSC) @(posedge pclk);
      check_bit("contact_auto", 1'b0, man_lamp);
      // Menu screens by Shift, mode keys on each
      kp.press(4'h2, 2000 * MSC + 10);
      check("menu", 32'h00000002, {29'h0, screen});
      kp.press(4'h8, 1);
      check_bit("am_up", 1'b1, man_lamp);
      kp.press(4'h4, 1);
      check_bit("am_down", 1'b0, man_lamp);
      kp.press(4'h2, 1);
      check("rl_screen", 32'h00000004, {29'h0, screen});
      kp.press(4'h8, 1);
      check_bit("rl_up", 1'b1, rem_lamp);
      kp.press(4'h4, 1);
      check_bit("rl_down", 1'b0, rem_lamp);
      kp.press(4'h2, 2000 * MSC + 10);
      check("monitor", 32'h00000001, {29'h0, screen});
      results();
   end
endmodule : mode_select_test
`default_nettype wire

// [rtl/mode_select.sv]
// Auto/Manual and Remote/Local mode selection with bumpless output handover.
// Assumes synchronous key levels, dry contacts on contact_input, an APB master,
// and an automatic output value supplied by the control loop on auto_output.
`include "mode_select_defines.svh"
`default_nettype none
module mode_select #(
   parameter int unsigned MS_CYCLES = `MS_CYCLES,
   parameter int unsigned OUT_WIDTH = 16,
   parameter int unsigned OUT_MAX   = 1000
) (
   // Clock, reset, enable
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Front keys, active high while pressed
   input  wire logic                 key_up,
   input  wire logic                 key_down,
   input  wire logic                 key_shift,
   input  wire logic                 key_direct,
   // Contacts: bit 0 auto/manual, bit 1 remote/local; 1 = closed
   input  wire logic [1:0]           contact_input,
   // Control loop
   input  wire logic [OUT_WIDTH-1:0] auto_output,
   output logic      [OUT_WIDTH-1:0] manipulated_output_value,
   output logic                      pid_preset,
   output logic      [OUT_WIDTH-1:0] pid_preset_value,
   // Indicators and actuator
   output logic                      manual_mode_lamp,
   output logic                      remote_mode_lamp,
   output logic                      output_hidden,
   output logic                      open_side_output,
   output logic                      close_side_output,
   output logic      [2:0]           screen
);

   // Saturating step of the manual output value
   function automatic logic [OUT_WIDTH-1:0] step_value(
      input logic [OUT_WIDTH-1:0] value,
      input logic                 up
   );
      logic [OUT_WIDTH-1:0] limit;
      limit = OUT_WIDTH'(OUT_MAX);
      if (up) begin
         step_value = (value >= limit) ? limit : value + 1'b1;
      end else begin
         step_value = (value == '0) ? value : value - 1'b1;
      end
   endfunction : step_value

   // Configuration and state
   logic [`CTRL_WIDTH-1:0]     ctrl;
   logic [15:0]                sample_ms;
   logic [17:0]                ms_cnt;
   logic                       ms_tick;
   logic [15:0]                sample_cnt;
   logic [1:0]                 contact_meta;
   logic [1:0]                 contact_sync;
   logic [1:0]                 contact_sampled;
   logic [1:0]                 contact_applied;
   logic [1:0]                 contact_pending;
   logic [15:0]                contact_delay [2];
   logic [11:0]                shift_ms;
   logic                       shift_done;
   logic [11:0]                hold_ms;
   logic [11:0]                repeat_ms;
   logic                       up_prev;
   logic                       down_prev;
   logic                       shift_prev;
   logic                       direct_prev;
   logic                       manual_prev;
   logic [OUT_WIDTH-1:0]       manual_value;
   mode_select_pkg::screen_type scr;

   // Decoded strobes and modes
   wire apb_setup     = psel & ~penable;
   wire apb_write     = psel & penable & pready & pwrite;
   wire sel_ctrl      = (paddr == `CTRL_ADDR);
   wire sel_sample    = (paddr == `SAMPLE_ADDR);
   wire sel_status    = (paddr == `STATUS_ADDR);
   wire sel_output    = (paddr == `OUTPUT_ADDR);
   wire unmapped      = ~(sel_ctrl | sel_sample | sel_status | sel_output);
   wire sample_tick   = ms_tick & (sample_cnt == 16'h0000);
   wire up_press      = key_up & ~up_prev;
   wire down_press    = key_down & ~down_prev;
   wire direct_press  = key_direct & ~direct_prev;
   wire shift_release = ~key_shift & shift_prev;
   wire in_menu       = (scr != mode_select_pkg::SCR_MONITOR);
   wire on_am_screen  = (scr == mode_select_pkg::SCR_AUTO_MANUAL);
   wire on_rl_screen  = (scr == mode_select_pkg::SCR_REMOTE_LOCAL);
   wire [1:0] direct_fn = ctrl[`CTRL_DIRECT_HI:`CTRL_DIRECT_LO];
   wire direct_am     = direct_press & (direct_fn == mode_select_pkg::DIRECT_AUTO_MANUAL);
   wire direct_rl     = direct_press & (direct_fn == mode_select_pkg::DIRECT_REMOTE_LOCAL);
   wire run           = ctrl[`CTRL_RUN];
   wire no_feedback   = ctrl[`CTRL_POSITION] & ~ctrl[`CTRL_FEEDBACK];

   // Both sources must agree before automatic or remote is taken
   wire contact_auto  = ~ctrl[`CTRL_AM_CONTACT] | contact_applied[0];
   wire contact_remote = ~ctrl[`CTRL_RL_CONTACT] | contact_applied[1];
   wire manual        = ctrl[`CTRL_KEY_MANUAL] | ~contact_auto;
   wire remote        = ctrl[`CTRL_KEY_REMOTE] & contact_remote;

   // Key/communication setting changes from the keypad
   wire set_manual    = (on_am_screen & up_press)
                      | (direct_am & ~ctrl[`CTRL_KEY_MANUAL]);
   wire set_auto      = (on_am_screen & down_press & ctrl[`CTRL_KEY_MANUAL])
                      | (direct_am & ctrl[`CTRL_KEY_MANUAL]);
   wire set_remote    = (on_rl_screen & up_press)
                      | (direct_rl & ~ctrl[`CTRL_KEY_REMOTE]);
   wire set_local     = (on_rl_screen & down_press & ctrl[`CTRL_KEY_REMOTE])
                      | (direct_rl & ctrl[`CTRL_KEY_REMOTE]);

   // Manual value adjustment: first press steps once, a long hold repeats
   wire adjust_keys   = manual & ~in_menu & ~no_feedback;
   wire held_repeat   = (hold_ms >= `REPEAT_START_MS) & ms_tick
                      & (repeat_ms == 12'h000);
   wire step_up       = adjust_keys & key_up & ~key_down & (up_press | held_repeat);
   wire step_down     = adjust_keys & key_down & ~key_up & (down_press | held_repeat);
   wire entering_manual = manual & ~manual_prev;
   wire leaving_manual  = ~manual & manual_prev;

   // Next values
   logic [`CTRL_WIDTH-1:0] next_ctrl;
   logic [OUT_WIDTH-1:0]   next_manual_value;
   logic [31:0]            next_prdata;
   mode_select_pkg::screen_type next_scr;

   // Control register: bus writes first, keypad changes override
   always_comb begin
      next_ctrl = ctrl;
      if (apb_write && sel_ctrl) begin
         next_ctrl = pwdata[`CTRL_WIDTH-1:0];
      end
      if (set_manual) begin
         next_ctrl[`CTRL_KEY_MANUAL] = 1'b1;
      end else if (set_auto) begin
         next_ctrl[`CTRL_KEY_MANUAL] = 1'b0;
      end
      if (set_remote) begin
         next_ctrl[`CTRL_KEY_REMOTE] = 1'b1;
      end else if (set_local) begin
         next_ctrl[`CTRL_KEY_REMOTE] = 1'b0;
      end
   end

   // Manual value: bumpless load or stored value, then key steps
   always_comb begin
      next_manual_value = manual_value;
      if (entering_manual) begin
         if (ctrl[`CTRL_BUMPLESS]) begin
            next_manual_value = auto_output;
         end
      end else if (step_up || step_down) begin
         next_manual_value = step_value(manual_value, step_up);
      end
   end

   // Screen walk: long Shift toggles the menu, short Shift moves between the two menu screens
   always_comb begin
      next_scr = scr;
      if (ms_tick && key_shift && !shift_done && shift_ms == `SHIFT_HOLD_MS - 12'h001) begin
         next_scr = in_menu ? mode_select_pkg::SCR_MONITOR
                            : mode_select_pkg::SCR_AUTO_MANUAL;
      end else if (shift_release && !shift_done) begin
         case (scr)
            mode_select_pkg::SCR_AUTO_MANUAL:  next_scr = mode_select_pkg::SCR_REMOTE_LOCAL;
            mode_select_pkg::SCR_REMOTE_LOCAL: next_scr = mode_select_pkg::SCR_AUTO_MANUAL;
            mode_select_pkg::SCR_MONITOR:      next_scr = mode_select_pkg::SCR_MONITOR;
            default:                           next_scr = mode_select_pkg::SCR_MONITOR;
         endcase
      end
   end

   // Read data mux, captured in the setup cycle
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (sel_ctrl) begin
         next_prdata[`CTRL_WIDTH-1:0] = ctrl;
      end else if (sel_sample) begin
         next_prdata[15:0] = sample_ms;
      end else if (sel_status) begin
         next_prdata[7:0] = {scr, contact_applied, remote, manual, run};
      end else if (sel_output) begin
         next_prdata[OUT_WIDTH-1:0] = manipulated_output_value;
      end
   end

   // APB answer one cycle after setup; access holds until then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= apb_setup;
         pslverr <= apb_setup & unmapped;
         prdata  <= apb_setup ? next_prdata : 32'h0000_0000;
      end
   end

   // Registers reachable from the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl      <= `CTRL_RESET;
         sample_ms <= `SAMPLE_RESET_MS;
      end else if (ce) begin
         ctrl <= next_ctrl;
         if (apb_write && sel_sample) begin
            sample_ms <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
         end
      end
   end

   // Millisecond base and sampling cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt     <= 18'h00000;
         ms_tick    <= 1'b0;
         sample_cnt <= 16'h0000;
      end else if (ce) begin
         ms_tick <= (ms_cnt == 18'(MS_CYCLES - 1));
         ms_cnt  <= (ms_cnt == 18'(MS_CYCLES - 1)) ? 18'h00000 : ms_cnt + 18'h00001;
         if (ms_tick) begin
            sample_cnt <= (sample_cnt == 16'h0000) ? sample_ms - 16'h0001
                                                   : sample_cnt - 16'h0001;
         end
      end
   end

   // Contacts: two-stage synchroniser, then one sample per sampling cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         contact_meta    <= 2'h0;
         contact_sync    <= 2'h0;
         contact_sampled <= 2'h0;
      end else if (ce) begin
         contact_meta <= contact_input;
         contact_sync <= contact_meta;
         if (sample_tick) begin
            contact_sampled <= contact_sync;
         end
      end
   end

   // Each change restarts a 200 ms plus one sampling cycle wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         contact_applied  <= 2'h0;
         contact_pending  <= 2'h0;
         contact_delay[0] <= 16'h0000;
         contact_delay[1] <= 16'h0000;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (contact_sampled[i] != contact_pending[i]) begin
               contact_pending[i] <= contact_sampled[i];
               contact_delay[i]   <= `CONTACT_DELAY_MS + sample_ms;
            end else if (contact_delay[i] != 16'h0000) begin
               if (ms_tick) begin
                  contact_delay[i] <= contact_delay[i] - 16'h0001;
               end
            end else begin
               contact_applied[i] <= contact_pending[i];
            end
         end
      end
   end

   // Key edge history and hold timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_prev     <= 1'b0;
         down_prev   <= 1'b0;
         shift_prev  <= 1'b0;
         direct_prev <= 1'b0;
         shift_ms    <= 12'h000;
         shift_done  <= 1'b0;
         hold_ms     <= 12'h000;
         repeat_ms   <= 12'h000;
      end else if (ce) begin
         up_prev     <= key_up;
         down_prev   <= key_down;
         shift_prev  <= key_shift;
         direct_prev <= key_direct;
         // A long Shift acts once; release re-arms it
         if (!key_shift) begin
            shift_ms   <= 12'h000;
            shift_done <= 1'b0;
         end else if (ms_tick && !shift_done) begin
            shift_ms   <= shift_ms + 12'h001;
            shift_done <= (shift_ms == `SHIFT_HOLD_MS - 12'h001);
         end
         // Hold timer saturates so a long press cannot wrap back to slow
         if (!(key_up ^ key_down)) begin
            hold_ms   <= 12'h000;
            repeat_ms <= 12'h000;
         end else if (ms_tick) begin
            if (hold_ms < `REPEAT_START_MS) begin
               hold_ms <= hold_ms + 12'h001;
            end
            if (hold_ms >= `REPEAT_START_MS) begin
               repeat_ms <= (repeat_ms == 12'h000) ? `REPEAT_EVERY_MS - 12'h001
                                                   : repeat_ms - 12'h001;
            end
         end
      end
   end

   // Screen state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scr <= mode_select_pkg::SCR_MONITOR;
      end else if (ce) begin
         scr <= next_scr;
      end
   end

   // Output handover between automatic and manual
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         manual_prev              <= 1'b0;
         manual_value             <= '0;
         manipulated_output_value <= '0;
         pid_preset               <= 1'b0;
         pid_preset_value         <= '0;
      end else if (ce) begin
         manual_prev  <= manual;
         manual_value <= next_manual_value;
         manipulated_output_value <= manual ? next_manual_value : auto_output;
         pid_preset   <= leaving_manual;
         if (leaving_manual) begin
            pid_preset_value <= manual_value;
         end
      end
   end

   // Lamps and position outputs; a stopped loop shows neither mode lamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         manual_mode_lamp  <= 1'b0;
         remote_mode_lamp  <= 1'b0;
         output_hidden     <= 1'b0;
         open_side_output  <= 1'b0;
         close_side_output <= 1'b0;
         screen            <= 3'h1;
      end else if (ce) begin
         manual_mode_lamp  <= manual & run;
         remote_mode_lamp  <= remote & run;
         output_hidden     <= manual & no_feedback;
         open_side_output  <= manual & no_feedback & ~in_menu & key_up & ~key_down;
         close_side_output <= manual & no_feedback & ~in_menu & key_down & ~key_up;
         screen            <= next_scr;
      end
   end

endmodule : mode_select
`default_nettype wire

// [rtl/mode_select_defines.svh]
// Register map, field positions, reset values and timing for the mode selector.
// Assumes an 8-bit APB byte address and one 32-bit word per register.
`ifndef MODE_SELECT_DEFINES_SVH
`define MODE_SELECT_DEFINES_SVH

`define CTRL_ADDR        8'h00
`define SAMPLE_ADDR      8'h04
`define STATUS_ADDR      8'h08
`define OUTPUT_ADDR      8'h0C

`define CTRL_KEY_MANUAL  0
`define CTRL_KEY_REMOTE  1
`define CTRL_RUN         2
`define CTRL_BUMPLESS    3
`define CTRL_DIRECT_LO   4
`define CTRL_DIRECT_HI   5
`define CTRL_AM_CONTACT  6
`define CTRL_RL_CONTACT  7
`define CTRL_POSITION    8
`define CTRL_FEEDBACK    9
`define CTRL_WIDTH       10
`define CTRL_RESET       10'h00C

`define SAMPLE_RESET_MS  16'h0064
`define CLK_PERIOD_NS    4
`define MS_NS            1000000
`define MS_CYCLES        (`MS_NS / `CLK_PERIOD_NS)
`define CONTACT_DELAY_MS 16'h00C8
`define SHIFT_HOLD_MS    12'h7D0
`define REPEAT_START_MS  12'h1F4
`define REPEAT_EVERY_MS  12'h014

`endif

// [rtl/mode_select_pkg.sv]
// Types shared by the mode selector.
// Assumes the defines header supplies all numeric constants.
`default_nettype none
package mode_select_pkg;

   typedef enum logic [2:0] {
      SCR_MONITOR      = 3'b001,
      SCR_AUTO_MANUAL  = 3'b010,
      SCR_REMOTE_LOCAL = 3'b100
   } screen_type;

   typedef enum logic [1:0] {
      DIRECT_NONE        = 2'h0,
      DIRECT_AUTO_MANUAL = 2'h1,
      DIRECT_REMOTE_LOCAL = 2'h2
   } direct_fn_type;

endpackage : mode_select_pkg
`default_nettype wire
